/* hw/dcc_top.sv */
// module: per-channel base, offset counter and size bookkeeping of the byte dma engine
`timescale 1ns/1ps
`default_nettype none
module dcc_top #(
  parameter int NUM_CHAN = 8
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic [7:0]                    sfr_addr_i,
  input  wire logic                          sfr_wr_i,
  input  wire logic                          sfr_rd_i,
  input  wire logic [7:0]                    sfr_wdata_i,
  output logic [7:0]                         sfr_rdata_o,
  input  wire logic                          byte_valid_i,
  output logic                               byte_ready_o,
  input  wire dcc_pkg::dcc_byte_t            byte_i,
  output logic                               ram_valid_o,
  input  wire logic                          ram_ready_i,
  output dcc_pkg::dcc_ram_req_t              ram_req_o,
  output logic [NUM_CHAN-1:0]                full_irq_o
);
  import dcc_pkg::*;

  initial
  begin
    if (NUM_CHAN < 2 || NUM_CHAN > (1 << CHAN_W))
      $error("dcc_top: NUM_CHAN must be 2..16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]           base_lo_reg [NUM_CHAN];
  logic [BASE_HI_W-1:0] base_hi_reg [NUM_CHAN];
  logic [CNT_W-1:0]     off_reg     [NUM_CHAN];
  logic [CNT_W-1:0]     size_reg    [NUM_CHAN];
  logic [7:0]           ctrl_reg    [NUM_CHAN];
  logic [CHAN_W-1:0]    sel_reg;
  logic                 ram_valid_reg;
  dcc_ram_req_t         ram_req_reg;
  logic [CHAN_W-1:0]    ram_chan_reg;
  logic [NUM_CHAN-1:0]  irq_reg;

  // ram address of a channel from its base and running offset
  function automatic logic [RAM_ADDR_W-1:0] ram_addr(input logic [7:0] lo,
                                                     input logic [BASE_HI_W-1:0] hi,
                                                     input logic [CNT_W-1:0] off);
    ram_addr = {hi, lo} + {2'b00, off};
  endfunction

  // channel index, forced to 0 when out of range so it cannot index past the arrays
  function automatic int unsigned chan_idx(input logic [CHAN_W-1:0] c);
    chan_idx = (int'(c) < NUM_CHAN) ? int'(c) : 0;
  endfunction

  // ----------------------------------------------------------------
  // byte path
  // ----------------------------------------------------------------
  dcc_byte_t fifo_out;
  logic      fifo_valid;
  logic      fifo_pop;
  logic      moved;
  logic      sel_ok;

  // load only into an empty output stage so the offset used is never stale
  assign fifo_pop = !ram_valid_reg;
  assign moved    = ram_valid_reg && ram_ready_i;
  assign sel_ok   = int'(sel_reg) < NUM_CHAN;

  dcc_fifo #(
    .WIDTH ($bits(dcc_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (byte_valid_i),
    .in_ready_o  (byte_ready_o),
    .in_data_i   (byte_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_out)
  );

  // output stage toward the data ram
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ram_valid_reg <= 1'b0;
      ram_req_reg   <= '0;
      ram_chan_reg  <= '0;
    end
    else if (ce_i)
    begin
      if (moved)
        ram_valid_reg <= 1'b0;
      else if (fifo_valid && fifo_pop)
      begin
        ram_valid_reg    <= 1'b1;
        ram_chan_reg     <= fifo_out.chan;
        ram_req_reg.data <= fifo_out.data;
        ram_req_reg.addr <= ram_addr(base_lo_reg[chan_idx(fifo_out.chan)],
                                     base_hi_reg[chan_idx(fifo_out.chan)],
                                     off_reg[chan_idx(fifo_out.chan)]);
      end
    end
  end

  assign ram_valid_o = ram_valid_reg;
  assign ram_req_o   = ram_req_reg;

  // ----------------------------------------------------------------
  // per-channel registers
  // ----------------------------------------------------------------
  // channel select
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sel_reg <= '0;
    else if (ce_i && sfr_wr_i && sfr_addr_i == ADDR_SEL)
      sel_reg <= sfr_wdata_i[CHAN_W-1:0];
  end

  // base, size and control: written only through the selected channel
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        base_lo_reg[i] <= RST_BYTE;
        base_hi_reg[i] <= RST_BASE_HI;
        size_reg[i]    <= RST_CNT;
        ctrl_reg[i]    <= RST_BYTE;
      end
    end
    else if (ce_i && sfr_wr_i && sel_ok)
    begin
      case (sfr_addr_i)
        ADDR_BASE_LO: base_lo_reg[chan_idx(sel_reg)] <= sfr_wdata_i;
        ADDR_BASE_HI: base_hi_reg[chan_idx(sel_reg)] <= sfr_wdata_i[BASE_HI_W-1:0];
        ADDR_SIZE_HI: size_reg[chan_idx(sel_reg)][9:8] <= sfr_wdata_i[1:0];
        ADDR_SIZE_LO: size_reg[chan_idx(sel_reg)][7:0] <= sfr_wdata_i;
        ADDR_CTRL:    ctrl_reg[chan_idx(sel_reg)]      <= sfr_wdata_i;
        default:      ;
      endcase
    end
  end

  // offset counters: a cpu offset write to the selected channel beats a same-cycle increment
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        off_reg[i] <= RST_CNT;
    end
    else if (ce_i)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        if (sfr_wr_i && sel_ok && i == int'(sel_reg) && sfr_addr_i == ADDR_OFF_HI)
          off_reg[i][9:8] <= sfr_wdata_i[1:0];
        else if (sfr_wr_i && sel_ok && i == int'(sel_reg) && sfr_addr_i == ADDR_OFF_LO)
          off_reg[i][7:0] <= sfr_wdata_i;
        else if (moved && i == int'(ram_chan_reg))
          off_reg[i] <= off_reg[i] + 1'b1;
      end
    end
  end

  // full-length event, one pulse per channel, gated by its enable
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_reg <= '0;
    else if (ce_i)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
        irq_reg[i] <= moved && i == int'(ram_chan_reg)
                      && (off_reg[i] + 1'b1) == size_reg[i]
                      && ctrl_reg[i][CTRL_FULL_LENGTH_IRQ_ENABLE_BIT];
    end
  end

  assign full_irq_o = irq_reg;

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    case (sfr_addr_i)
      ADDR_SEL:     rd_mux = {{(8-CHAN_W){1'b0}}, sel_reg};
      ADDR_BASE_LO: rd_mux = base_lo_reg[chan_idx(sel_reg)];
      ADDR_BASE_HI: rd_mux = {4'h0, base_hi_reg[chan_idx(sel_reg)]};
      ADDR_OFF_HI:  rd_mux = {6'h00, off_reg[chan_idx(sel_reg)][9:8]};
      ADDR_OFF_LO:  rd_mux = off_reg[chan_idx(sel_reg)][7:0];
      ADDR_SIZE_HI: rd_mux = {6'h00, size_reg[chan_idx(sel_reg)][9:8]};
      ADDR_SIZE_LO: rd_mux = size_reg[chan_idx(sel_reg)][7:0];
      ADDR_CTRL:    rd_mux = ctrl_reg[chan_idx(sel_reg)];
      default:      rd_mux = 8'h00;
    endcase
    if (sfr_addr_i != ADDR_SEL && !sel_ok)
      rd_mux = 8'h00;
  end

  // read data registered, valid the cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      sfr_rdata_o <= RST_BYTE;
    else if (ce_i && sfr_rd_i)
      sfr_rdata_o <= rd_mux;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_off_hi_zero : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_rd_i && sfr_addr_i == ADDR_OFF_HI |=> sfr_rdata_o[7:2] == 6'h00)
    else $error("offset high unused bits not zero");
  chk_size_hi_zero : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_rd_i && sfr_addr_i == ADDR_SIZE_HI |=> sfr_rdata_o[7:2] == 6'h00)
    else $error("size high unused bits not zero");
  chk_off_increment : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && moved && !sfr_wr_i |=>
      off_reg[chan_idx(ram_chan_reg)] == $past(off_reg[chan_idx(ram_chan_reg)]) + 1'b1)
    else $error("offset did not advance after a moved byte");
  chk_off_lo_write : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_wr_i && sel_ok && sfr_addr_i == ADDR_OFF_LO |=>
      off_reg[chan_idx($past(sel_reg))][7:0] == $past(sfr_wdata_i))
    else $error("offset low write lost");
  chk_base_lo_read : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_rd_i && sel_ok && sfr_addr_i == ADDR_BASE_LO |=>
      sfr_rdata_o == base_lo_reg[chan_idx($past(sel_reg))])
    else $error("base low read mismatch");
  chk_addr_sum : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && !ram_valid_reg && fifo_valid |=> ram_valid_reg && ram_req_reg.addr ==
      ram_addr($past(base_lo_reg[chan_idx(fifo_out.chan)]),
               $past(base_hi_reg[chan_idx(fifo_out.chan)]),
               $past(off_reg[chan_idx(fifo_out.chan)])))
    else $error("ram address is not base plus offset");
  chk_irq_cause : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    |full_irq_o |-> $past(moved) && full_irq_o[chan_idx(ram_chan_reg)]
      && off_reg[chan_idx(ram_chan_reg)] == size_reg[chan_idx(ram_chan_reg)])
    else $error("full-length pulse without offset reaching size");
  chk_irq_enable : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    |full_irq_o |-> $past(ctrl_reg[chan_idx(ram_chan_reg)][CTRL_FULL_LENGTH_IRQ_ENABLE_BIT]))
    else $error("full-length pulse while disabled");
  chk_size_hi_write : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_wr_i && sel_ok && sfr_addr_i == ADDR_SIZE_HI |=>
      size_reg[chan_idx($past(sel_reg))][9:8] == $past(sfr_wdata_i[1:0]))
    else $error("size high write lost");
  chk_sel_write : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_wr_i && sfr_addr_i == ADDR_SEL |=> sel_reg == $past(sfr_wdata_i[CHAN_W-1:0]))
    else $error("channel select not taken");
  chk_base_hi_write : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i && sfr_wr_i && sel_ok && sfr_addr_i == ADDR_BASE_HI |=>
      base_hi_reg[chan_idx($past(sel_reg))] == $past(sfr_wdata_i[3:0]))
    else $error("base high write lost");
endmodule
`default_nettype wire

/* include/dcc_pkg.sv */
// package: register map, field layout and carriers of the dma address/size counters
`default_nettype none
package dcc_pkg;
  // ----------------------------------------------------------------
  // sfr addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'hC9;
  localparam logic [7:0] ADDR_SEL      = 8'hCA;
  localparam logic [7:0] ADDR_BASE_HI  = 8'hCB;
  localparam logic [7:0] ADDR_BASE_LO  = 8'hCC;
  localparam logic [7:0] ADDR_OFF_HI   = 8'hCD;
  localparam logic [7:0] ADDR_OFF_LO   = 8'hCE;
  localparam logic [7:0] ADDR_SIZE_HI  = 8'hCF;
  localparam logic [7:0] ADDR_SIZE_LO  = 8'hD0;
  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         CNT_W         = 10;
  localparam int         BASE_HI_W     = 4;
  localparam int         RAM_ADDR_W    = 12;
  localparam int         CHAN_W        = 4;
  localparam int         CTRL_FULL_LENGTH_IRQ_ENABLE_BIT = 7;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [9:0] RST_CNT       = 10'h000;
  localparam logic [3:0] RST_BASE_HI   = 4'h0;
  localparam int         FIFO_DEPTH    = 16;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic [7:0]        data;
  } dcc_byte_t;
  typedef struct packed {
    logic [RAM_ADDR_W-1:0] addr;
    logic [7:0]            data;
  } dcc_ram_req_t;
endpackage
`default_nettype wire

/* hw/dcc_fifo.sv */
// module: parameterised valid/ready fifo for the byte path
`timescale 1ns/1ps
`default_nettype none
module dcc_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("dcc_fifo: DEPTH must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic             push;
  logic             pop;
  logic [AW:0]      fill_cnt;
  // full when pointers differ only in the wrap bit
  assign in_ready_o  = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_ptr_reg != rd_ptr_reg;
  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;
  assign out_data_o  = mem[rd_ptr_reg[AW-1:0]];
  // fill level kept at pointer width so the difference wraps with the pointers
  assign fill_cnt    = wr_ptr_reg - rd_ptr_reg;
  // storage, no reset needed since empty hides stale words
  always_ff @(posedge ref_clk_i)
  begin
    if (push)
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
  end
  // pointers
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
  chk_fifo_no_overrun : assert property (@(posedge ref_clk_i) disable iff (rst_i)
    fill_cnt <= DEPTH)
    else $error("fifo holds more words than its depth");
endmodule
`default_nettype wire

/* dv/dcc_ram_model.sv */
// partner model: data ram write port that answers one cycle late and can stall
`timescale 1ns/1ps
`default_nettype none
module dcc_ram_model
  import dcc_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic          ram_valid_i,
  input  wire logic          stall_i,
  input  wire dcc_ram_req_t  ram_req_i,
  output logic               ram_ready_o,
  output logic [11:0]        last_addr_o,
  output logic [7:0]         last_data_o,
  output var int             n_got_o
);
  // ----------------------------------------------------------------
  // acceptance
  // ----------------------------------------------------------------
  // ready comes a cycle after valid, so the request must really stand
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ram_ready_o <= 1'b0;
    else
      ram_ready_o <= ram_valid_i && !ram_ready_o && !stall_i;
  end
  // record each accepted write
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      n_got_o     <= 0;
      last_addr_o <= 12'h000;
      last_data_o <= 8'h00;
    end
    else if (ram_valid_i && ram_ready_o)
    begin
      n_got_o     <= n_got_o + 1;
      last_addr_o <= ram_req_i.addr;
      last_data_o <= ram_req_i.data;
    end
  end
endmodule
`default_nettype wire

/* dv/dcc_top_tb.sv */
// testbench: register access, byte path and fifo back-pressure of the dma counters
`timescale 1ns/1ps
`default_nettype none
module dcc_top_tb;
  import dcc_pkg::*;
  logic         ref_clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic [7:0]   sfr_addr_i = 8'h00;
  logic         sfr_wr_i = 1'b0;
  logic         sfr_rd_i = 1'b0;
  logic [7:0]   sfr_wdata_i = 8'h00;
  logic [7:0]   sfr_rdata_o;
  logic         byte_valid_i = 1'b0;
  logic         byte_ready_o;
  dcc_byte_t    byte_i = '0;
  logic         ram_valid_o;
  logic         ram_ready_i;
  dcc_ram_req_t ram_req_o;
  logic [7:0]   full_irq_o;
  logic         stall = 1'b0;
  logic         ce = 1'b1;
  logic [11:0]  got_addr;
  logic [7:0]   got_data;
  int           n_got;
  int           n_irq [8] = '{default: 0};
  int           n_mismatch = 0;
  int           n_tests = 0;
  // ----------------------------------------------------------------
  // clock, design and partner
  // ----------------------------------------------------------------
  always #25 ref_clk_i = ~ref_clk_i;
  dcc_top #(.NUM_CHAN(8)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce),
    .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .byte_valid_i(byte_valid_i),
    .byte_ready_o(byte_ready_o), .byte_i(byte_i), .ram_valid_o(ram_valid_o),
    .ram_ready_i(ram_ready_i), .ram_req_o(ram_req_o), .full_irq_o(full_irq_o));
  dcc_ram_model M (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ram_valid_i(ram_valid_o),
    .stall_i(stall), .ram_req_i(ram_req_o), .ram_ready_o(ram_ready_i),
    .last_addr_o(got_addr), .last_data_o(got_data), .n_got_o(n_got));
  // irq pulses are one cycle wide, so count them at every settled falling edge
  always @(negedge ref_clk_i)
    for (int i = 0; i < 8; i++)
      if (full_irq_o[i] === 1'b1)
        n_irq[i]++;
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up(input string what);
    n_mismatch++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    close_out();
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_wr_i = 1'b0;
  endtask
  // read data lands one cycle after the strobe edge and then holds
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge ref_clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge ref_clk_i);
    sfr_rd_i = 1'b0;
    @(negedge ref_clk_i);
    check({4'h0, sfr_rdata_o}, {4'h0, exp}, what);
  endtask
  // offset is loaded on purpose here so that boundaries can be hit
  // select before setup
  task automatic setup(input logic [3:0] ch, input logic [11:0] base, input logic [9:0] off,
                       input logic [9:0] size, input logic [7:0] ctrl);
    sfr_write(ADDR_SEL, {4'h0, ch});
    sfr_write(ADDR_BASE_HI, {4'h0, base[11:8]});
    sfr_write(ADDR_BASE_LO, base[7:0]);
    sfr_write(ADDR_OFF_HI, {6'h00, off[9:8]});
    sfr_write(ADDR_OFF_LO, off[7:0]);
    sfr_write(ADDR_SIZE_HI, {6'h00, size[9:8]});
    sfr_write(ADDR_SIZE_LO, size[7:0]);
    sfr_write(ADDR_CTRL, ctrl);
  endtask
  task automatic send(input logic [3:0] ch, input logic [7:0] d);
    int i;
    @(negedge ref_clk_i);
    byte_i = '{chan: ch, data: d};
    byte_valid_i = 1'b1;
    for (i = 0; i < 40 && byte_ready_o !== 1'b1; i++)
      @(negedge ref_clk_i);
    if (i == 40)
      give_up("byte take");
    @(negedge ref_clk_i);
    byte_valid_i = 1'b0;
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 80 && n_got < n; i++)
      @(negedge ref_clk_i);
    if (n_got < n)
      give_up("ram write");
    repeat (3) @(negedge ref_clk_i);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_and_unused;
    chk_reg(ADDR_OFF_HI, 8'h00, "offset high reset");
    chk_reg(ADDR_SIZE_HI, 8'h00, "size high reset");
    chk_reg(ADDR_BASE_LO, 8'h00, "base low reset");
    chk_reg(ADDR_OFF_LO, 8'h00, "offset low reset");
    chk_reg(ADDR_SIZE_LO, 8'h00, "size low reset");
    sfr_write(ADDR_OFF_HI, 8'hFF);
    sfr_write(ADDR_SIZE_HI, 8'hFE);
    chk_reg(ADDR_OFF_HI, 8'h03, "offset high unused bits");
    chk_reg(ADDR_SIZE_HI, 8'h02, "size high unused bits");
    $display("test reset_and_unused done");
  endtask
  task automatic t_select;
    setup(4'h1, 12'h111, 10'h011, 10'h2A1, 8'h00);
    setup(4'h2, 12'h222, 10'h122, 10'h1B2, 8'h00);
    sfr_write(ADDR_SEL, 8'h01);
    chk_reg(ADDR_BASE_LO, 8'h11, "base low of first channel");
    chk_reg(ADDR_BASE_HI, 8'h01, "base high of first channel");
    chk_reg(ADDR_SIZE_HI, 8'h02, "size high of first channel");
    chk_reg(ADDR_SIZE_LO, 8'hA1, "size low of first channel");
    sfr_write(ADDR_SEL, 8'h02);
    chk_reg(ADDR_OFF_HI, 8'h01, "offset high of second channel");
    chk_reg(ADDR_BASE_LO, 8'h22, "base low of second channel");
    chk_reg(ADDR_BASE_HI, 8'h02, "base high of second channel");
    $display("test select done");
  endtask
  // offset crosses the low/high boundary and reaches size on the second byte
  task automatic t_stream;
    setup(4'h3, 12'hA40, 10'h1FE, 10'h200, 8'h80);
    send(4'h3, 8'h5A);
    wait_got(1);
    check(got_addr, 12'hC3E, "first ram address");
    check({4'h0, got_data}, 12'h05A, "first ram data");
    chk_reg(ADDR_OFF_LO, 8'hFF, "offset low after one byte");
    check(n_irq[3][11:0], 12'h000, "no early full event");
    send(4'h3, 8'hA5);
    wait_got(2);
    check(got_addr, 12'hC3F, "second ram address");
    chk_reg(ADDR_OFF_LO, 8'h00, "offset low after carry");
    chk_reg(ADDR_OFF_HI, 8'h02, "offset high after carry");
    check(n_irq[3][11:0], 12'h001, "full event on reaching size");
    // offset zeroed before the channel starts
    setup(4'h4, 12'h0F0, 10'h000, 10'h001, 8'h00);
    send(4'h4, 8'h33);
    wait_got(3);
    check(got_addr, 12'h0F0, "base is start address");
    check(n_irq[4][11:0], 12'h000, "masked full event");
    $display("test stream done");
  endtask
  // stalled ram: the fifo must refuse, then drain everything in order
  task automatic t_fifo;
    int n;
    // offset zeroed before the channel starts
    setup(4'h5, 12'h000, 10'h000, 10'h3FF, 8'h80);
    stall = 1'b1;
    @(negedge ref_clk_i);
    for (n = 0; n < 30 && byte_ready_o === 1'b1; n++)
    begin
      byte_i = '{chan: 4'h5, data: n[7:0]};
      byte_valid_i = 1'b1;
      @(negedge ref_clk_i);
    end
    byte_valid_i = 1'b0;
    // fifo words plus the one held in the output stage
    check(n[11:0], 12'(FIFO_DEPTH + 1), "fifo refuses when full");
    stall = 1'b0;
    wait_got(3 + n);
    check(got_addr, n[11:0] - 12'h001, "last drained address");
    check({4'h0, got_data}, n[11:0] - 12'h001, "last drained data");
    chk_reg(ADDR_OFF_LO, n[7:0], "offset after drain");
    check(n_irq[5][11:0], 12'h000, "size not reached");
    $display("test fifo done");
  endtask
  // clock enable low freezes writes; an absent channel swallows writes, reads zero
  task automatic t_freeze;
    ce = 1'b0;
    sfr_write(ADDR_OFF_LO, 8'h77);
    ce = 1'b1;
    chk_reg(ADDR_OFF_LO, 8'h11, "offset held while enable low");
    sfr_write(ADDR_SEL, 8'h09);
    sfr_write(ADDR_BASE_LO, 8'h44);
    chk_reg(ADDR_SEL, 8'h09, "out-of-range select kept");
    chk_reg(ADDR_BASE_LO, 8'h00, "absent channel reads zero");
    sfr_write(ADDR_SEL, 8'h00);
    chk_reg(ADDR_BASE_LO, 8'h00, "absent channel write ignored");
    $display("test freeze done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    t_reset_and_unused();
    t_select();
    t_stream();
    t_fifo();
    t_freeze();
    close_out();
  end
endmodule
`default_nettype wire
